/* File: hw/torque_supervisor_pkg.sv */
// Package with register map, reset values and timing constants of the torque-off and protection supervisor.
package torque_supervisor_pkg;
	localparam logic [7:0] CTRL_ADDR     = 8'h00;
	localparam logic [7:0] OVER_V_ADDR   = 8'h04;
	localparam logic [7:0] UNDER_V_ADDR  = 8'h08;
	localparam logic [7:0] I_LIMIT_ADDR  = 8'h0c;
	localparam logic [7:0] STALL_I_ADDR  = 8'h10;
	localparam logic [7:0] STALL_T_ADDR  = 8'h14;
	localparam logic [7:0] STATUS_ADDR   = 8'h18;
	localparam logic [7:0] MASK_ADDR     = 8'h1c;
	localparam logic [7:0] STATE_ADDR    = 8'h20;

	localparam int CTRL_STO_EN   = 0;
	localparam int CTRL_TCP      = 1;
	localparam int CTRL_CAN      = 2;
	localparam int CTRL_ZERO_CMD = 3;

	localparam int EV_STO_FAULT  = 0;
	localparam int EV_TEST_FAIL  = 1;
	localparam int EV_OVER_V     = 2;
	localparam int EV_UNDER_V    = 3;
	localparam int EV_STALL      = 4;
	localparam int EV_SHORT      = 5;
	localparam int EV_I_LIMIT    = 6;
	localparam int EV_W          = 7;

	// Voltages in 0.1 V units, currents in 0.1 A units, stall time in ms.
	localparam logic [15:0] OVER_V_RST   = 16'h0258;
	localparam logic [15:0] OVER_V_MIN   = 16'h0032;
	localparam logic [15:0] OVER_V_MAX   = 16'h0258;
	localparam logic [15:0] UNDER_V_RST  = 16'h0032;
	localparam logic [15:0] UNDER_V_MIN  = 16'h0000;
	localparam logic [15:0] UNDER_V_MAX  = 16'h01f4;
	localparam logic [15:0] I_LIMIT_RST  = 16'h01f4;
	localparam logic [15:0] I_MIN        = 16'h0064;
	localparam logic [15:0] I_MAX        = 16'h0258;
	localparam logic [15:0] STALL_I_RST  = 16'h0258;
	localparam logic [15:0] STALL_T_RST  = 16'h01f4;
	localparam logic [15:0] STALL_T_MIN  = 16'h0001;
	localparam logic [15:0] STALL_T_MAX  = 16'hfde8;
	localparam logic [15:0] SHORT_I      = 16'h02d0;

	localparam int CLK_PERIOD_NS  = 25;
	localparam int SELFTEST_NS    = 10000;
	localparam int SELFTEST_CYC   = (SELFTEST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LED_PERIOD_MS  = 2000;
	localparam int LED_FLASH_MS   = 100;
	localparam int LED_GAP_MS     = 300;

	typedef enum logic [4:0] {
		TEST_IDLE = 5'h01,
		TEST_HIGH = 5'h02,
		TEST_LOW  = 5'h04,
		TEST_PASS = 5'h08,
		TEST_FAIL = 5'h10
	} test_state_t;
endpackage : torque_supervisor_pkg

/* File: hw/torque_off_supervisor.sv */
// Torque-off supervision, supply and current protections, network mode interlock and status indicator.
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
// Contract
// - run only while both inputs high
// - self-test at power-up and both-high rise
// - passing self-test allows power stage on
// - test fail or inputs not both high: off
// - exactly one input high raises fault alarm
// - supervision acts only when enabled; default bypassed
// - TCP and CAN modes never both active
// - reset gives TCP on, CAN off
// - status indicator pattern repeats every two seconds
// - over-voltage threshold 5 to 60 V, default 60
// - under-voltage threshold 0 to 50 V, default 5
// - current limit 10 to 60 A, default 50
// - stall after current exceeds threshold for timeout
// - stall current threshold 10 to 60 A, default 60
// - short circuit stops output until zero command
module torque_off_supervisor #(
	parameter int MS_CYCLES = 40000,
	parameter int MEAS_W    = 16
) (
	// APB slave.
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	// Torque-off inputs and self-test path.
	input  wire logic              torque_off_input_a,
	input  wire logic              torque_off_input_b,
	input  wire logic              test_echo,
	output logic                   test_drive,
	// Measurements.
	input  wire logic              sample_valid,
	input  wire logic [MEAS_W-1:0] supply_volts,
	input  wire logic [MEAS_W-1:0] motor_current,
	// Power stage, network and indicator.
	output logic                   power_stage_enable,
	output logic                   current_limit_active,
	output logic                   tcp_mode,
	output logic                   can_mode,
	output logic                   status_led,
	output logic                   status_led_fault,
	output logic                   irq
);
	function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clamp

	localparam int MS_W = $clog2(MS_CYCLES + 1);

	logic                   sto_enable;
	logic [15:0]            over_v_th;
	logic [15:0]            under_v_th;
	logic [15:0]            i_limit;
	logic [15:0]            stall_i;
	logic [15:0]            stall_t;
	logic [torque_supervisor_pkg::EV_W-1:0] status;
	logic [torque_supervisor_pkg::EV_W-1:0] mask;
	logic [torque_supervisor_pkg::EV_W-1:0] events;
	logic                   over_v;
	logic                   under_v;
	logic                   stall;
	logic                   short_fault;
	logic [15:0]            stall_ms;
	logic                   stall_over;
	logic [MS_W-1:0]        ms_cnt;
	logic                   ms_tick;
	logic [10:0]            led_ms;
	logic                   both_high_q;
	logic                   test_start;
	logic [15:0]            test_cnt;
	torque_supervisor_pkg::test_state_t test_state;
	logic                   wr_en;
	logic                   rd_en;
	logic                   zero_cmd;
	logic                   both_high;
	logic                   one_high;
	logic                   sto_ok;
	logic [31:0]            next_prdata;
	logic                   addr_ok;

	assign both_high = torque_off_input_a & torque_off_input_b;
	assign one_high  = torque_off_input_a ^ torque_off_input_b;
	assign wr_en     = psel & penable & pready & pwrite;
	assign rd_en     = psel & penable & pready & ~pwrite;
	assign zero_cmd  = wr_en && paddr == torque_supervisor_pkg::CTRL_ADDR && pwdata[torque_supervisor_pkg::CTRL_ZERO_CMD];
	// With supervision bypassed the stage is governed by the protections alone.
	// A pass from before the inputs last rose does not count, so the stage waits for the fresh test.
	assign sto_ok    = ~sto_enable | (both_high & both_high_q & ~test_start &
		test_state == torque_supervisor_pkg::TEST_PASS);

	// The answer comes one cycle into the access phase so that prdata is a flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~addr_ok;
			prdata  <= (psel & penable & ~pready & ~pwrite) ? next_prdata : 32'h0000_0000;
		end
	end

	always_comb begin
		addr_ok     = 1'b1;
		next_prdata = 32'h0000_0000;
		case (paddr)
			torque_supervisor_pkg::CTRL_ADDR:    next_prdata = {29'h0, can_mode, tcp_mode, sto_enable};
			torque_supervisor_pkg::OVER_V_ADDR:  next_prdata = {16'h0, over_v_th};
			torque_supervisor_pkg::UNDER_V_ADDR: next_prdata = {16'h0, under_v_th};
			torque_supervisor_pkg::I_LIMIT_ADDR: next_prdata = {16'h0, i_limit};
			torque_supervisor_pkg::STALL_I_ADDR: next_prdata = {16'h0, stall_i};
			torque_supervisor_pkg::STALL_T_ADDR: next_prdata = {16'h0, stall_t};
			torque_supervisor_pkg::STATUS_ADDR:  next_prdata = {25'h0, status};
			torque_supervisor_pkg::MASK_ADDR:    next_prdata = {25'h0, mask};
			torque_supervisor_pkg::STATE_ADDR:   next_prdata = {20'h0, test_state, torque_off_input_b,
				torque_off_input_a, short_fault, stall, under_v, over_v, power_stage_enable};
			default: addr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sto_enable <= 1'b0;
			tcp_mode   <= 1'b1;
			can_mode   <= 1'b0;
			over_v_th  <= torque_supervisor_pkg::OVER_V_RST;
			under_v_th <= torque_supervisor_pkg::UNDER_V_RST;
			i_limit    <= torque_supervisor_pkg::I_LIMIT_RST;
			stall_i    <= torque_supervisor_pkg::STALL_I_RST;
			stall_t    <= torque_supervisor_pkg::STALL_T_RST;
			mask       <= '0;
		end else if (wr_en) begin
			case (paddr)
				torque_supervisor_pkg::CTRL_ADDR: begin
					sto_enable <= pwdata[torque_supervisor_pkg::CTRL_STO_EN];
					// A write asking for both modes at once is refused and leaves the pair unchanged.
					if (!(pwdata[torque_supervisor_pkg::CTRL_TCP] & pwdata[torque_supervisor_pkg::CTRL_CAN])) begin
						tcp_mode <= pwdata[torque_supervisor_pkg::CTRL_TCP];
						can_mode <= pwdata[torque_supervisor_pkg::CTRL_CAN];
					end
				end
				torque_supervisor_pkg::OVER_V_ADDR: over_v_th <= clamp(pwdata[15:0], torque_supervisor_pkg::OVER_V_MIN,
					torque_supervisor_pkg::OVER_V_MAX);
				torque_supervisor_pkg::UNDER_V_ADDR: under_v_th <= clamp(pwdata[15:0], torque_supervisor_pkg::UNDER_V_MIN,
					torque_supervisor_pkg::UNDER_V_MAX);
				torque_supervisor_pkg::I_LIMIT_ADDR: i_limit <= clamp(pwdata[15:0], torque_supervisor_pkg::I_MIN,
					torque_supervisor_pkg::I_MAX);
				torque_supervisor_pkg::STALL_I_ADDR: stall_i <= clamp(pwdata[15:0], torque_supervisor_pkg::I_MIN,
					torque_supervisor_pkg::I_MAX);
				torque_supervisor_pkg::STALL_T_ADDR: stall_t <= clamp(pwdata[15:0], torque_supervisor_pkg::STALL_T_MIN,
					torque_supervisor_pkg::STALL_T_MAX);
				torque_supervisor_pkg::MASK_ADDR: mask <= pwdata[torque_supervisor_pkg::EV_W-1:0];
				default: ;
			endcase
		end
	end

	// Self-test: drive the test line high then low and expect the echo to follow each level.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			both_high_q <= 1'b0;
			test_start  <= 1'b1;
		end else begin
			both_high_q <= both_high;
			test_start  <= both_high & ~both_high_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			test_state <= torque_supervisor_pkg::TEST_IDLE;
			test_cnt   <= 16'h0000;
			test_drive <= 1'b0;
		end else if (test_start) begin
			test_state <= torque_supervisor_pkg::TEST_HIGH;
			test_cnt   <= 16'h0000;
			test_drive <= 1'b1;
		end else begin
			case (test_state)
				torque_supervisor_pkg::TEST_HIGH: begin
					test_cnt <= test_cnt + 16'h0001;
					if (test_cnt == 16'(torque_supervisor_pkg::SELFTEST_CYC - 1)) begin
						test_cnt   <= 16'h0000;
						test_drive <= 1'b0;
						test_state <= test_echo ? torque_supervisor_pkg::TEST_LOW : torque_supervisor_pkg::TEST_FAIL;
					end
				end
				torque_supervisor_pkg::TEST_LOW: begin
					test_cnt <= test_cnt + 16'h0001;
					if (test_cnt == 16'(torque_supervisor_pkg::SELFTEST_CYC - 1)) begin
						test_state <= test_echo ? torque_supervisor_pkg::TEST_FAIL : torque_supervisor_pkg::TEST_PASS;
					end
				end
				torque_supervisor_pkg::TEST_IDLE,
				torque_supervisor_pkg::TEST_PASS,
				torque_supervisor_pkg::TEST_FAIL: test_drive <= 1'b0;
				default: test_state <= torque_supervisor_pkg::TEST_FAIL;
			endcase
		end
	end

	// Millisecond time base shared by the stall timer and the indicator.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_cnt  <= '0;
			ms_tick <= 1'b0;
		end else begin
			ms_tick <= ms_cnt == MS_W'(MS_CYCLES - 1);
			ms_cnt  <= (ms_cnt == MS_W'(MS_CYCLES - 1)) ? '0 : ms_cnt + MS_W'(1);
		end
	end

	// Voltage flags follow each sample; they recover when a sample is back in range.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			over_v               <= 1'b0;
			under_v              <= 1'b0;
			current_limit_active <= 1'b0;
			stall_over           <= 1'b0;
		end else if (sample_valid) begin
			over_v               <= 16'(supply_volts) > over_v_th;
			under_v              <= 16'(supply_volts) < under_v_th;
			current_limit_active <= 16'(motor_current) > i_limit;
			stall_over           <= 16'(motor_current) > stall_i;
		end
	end

	// Stall and short circuit latch until a zero command, since the motor must be restarted deliberately.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stall_ms    <= 16'h0000;
			stall       <= 1'b0;
			short_fault <= 1'b0;
		end else begin
			if (!stall_over) begin
				stall_ms <= 16'h0000;
			end else if (ms_tick && stall_ms != 16'hffff) begin
				stall_ms <= stall_ms + 16'h0001;
			end
			if (stall_over && stall_ms >= stall_t) begin
				stall <= 1'b1;
			end else if (zero_cmd) begin
				stall <= 1'b0;
			end
			if (sample_valid && 16'(motor_current) > torque_supervisor_pkg::SHORT_I) begin
				short_fault <= 1'b1;
			end else if (zero_cmd) begin
				short_fault <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_stage_enable <= 1'b0;
		end else begin
			power_stage_enable <= sto_ok & ~short_fault & ~stall & ~over_v & ~under_v;
		end
	end

	always_comb begin
		events = '0;
		events[torque_supervisor_pkg::EV_STO_FAULT] = sto_enable & one_high;
		events[torque_supervisor_pkg::EV_TEST_FAIL] = sto_enable & test_state == torque_supervisor_pkg::TEST_FAIL;
		events[torque_supervisor_pkg::EV_OVER_V]    = over_v;
		events[torque_supervisor_pkg::EV_UNDER_V]   = under_v;
		events[torque_supervisor_pkg::EV_STALL]     = stall;
		events[torque_supervisor_pkg::EV_SHORT]     = short_fault;
		events[torque_supervisor_pkg::EV_I_LIMIT]   = current_limit_active;
	end

	// A new event in the cycle of the clearing read survives the clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= '0;
			irq    <= 1'b0;
		end else begin
			status <= ((rd_en && paddr == torque_supervisor_pkg::STATUS_ADDR) ? '0 : status) | events;
			irq    <= |(status & mask);
		end
	end

	// One flash per period when healthy, a double flash in fault colour on any exception.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			led_ms           <= 11'h000;
			status_led       <= 1'b0;
			status_led_fault <= 1'b0;
		end else begin
			if (ms_tick) begin
				led_ms <= (led_ms == 11'(torque_supervisor_pkg::LED_PERIOD_MS - 1)) ? 11'h000 : led_ms + 11'h001;
			end
			status_led_fault <= |status;
			status_led       <= (led_ms < 11'(torque_supervisor_pkg::LED_FLASH_MS)) ||
				(|status && led_ms >= 11'(torque_supervisor_pkg::LED_GAP_MS) &&
				led_ms < 11'(torque_supervisor_pkg::LED_GAP_MS + torque_supervisor_pkg::LED_FLASH_MS));
		end
	end

	sequence both_rise_s;
		both_high & ~both_high_q;
	endsequence

	sequence test_run_s;
		test_state == torque_supervisor_pkg::TEST_HIGH;
	endsequence

	stage_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		sto_enable && !both_high |=> !power_stage_enable)
		else $error("power stage on with torque-off inputs not both high");
	stage_allow_a: assert property (@(posedge pclk) disable iff (!presetn)
		power_stage_enable && $past(sto_enable) |-> $past(test_state) == torque_supervisor_pkg::TEST_PASS)
		else $error("power stage on without passed self-test");
	test_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
		both_rise_s |=> ##1 test_run_s)
		else $error("self-test not started on both inputs rising");
	sto_alarm_a: assert property (@(posedge pclk) disable iff (!presetn)
		sto_enable && one_high |=> status[torque_supervisor_pkg::EV_STO_FAULT])
		else $error("single input high did not raise fault");
	retest_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		sto_enable && both_rise_s |=> !power_stage_enable)
		else $error("power stage on before the new self-test");
	mode_excl_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(tcp_mode && can_mode))
		else $error("tcp and can modes both active");
	short_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		short_fault && !zero_cmd |=> short_fault ##1 !power_stage_enable)
		else $error("short fault released without zero command");
	over_trip_a: assert property (@(posedge pclk) disable iff (!presetn)
		sample_valid && 16'(supply_volts) > over_v_th |=> over_v ##1 !power_stage_enable)
		else $error("over-voltage sample did not trip");
	thresh_range_a: assert property (@(posedge pclk) disable iff (!presetn)
		i_limit >= torque_supervisor_pkg::I_MIN && i_limit <= torque_supervisor_pkg::I_MAX &&
		stall_i >= torque_supervisor_pkg::I_MIN && under_v_th <= torque_supervisor_pkg::UNDER_V_MAX)
		else $error("threshold outside its range");
	stall_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(stall) |-> $past(stall_over) && $past(stall_ms) >= $past(stall_t))
		else $error("stall declared before timeout");
	led_period_a: assert property (@(posedge pclk) disable iff (!presetn)
		led_ms < 11'(torque_supervisor_pkg::LED_PERIOD_MS))
		else $error("indicator period exceeded");
endmodule : torque_off_supervisor

/* File: sim/torque_off_partner.sv */
// Model of the external safety controller and of the torque-off path response.
`timescale 1ns/1ps
module torque_off_partner (
	// Clock and reset.
	input  wire logic pclk,
	input  wire logic presetn,
	// Bench commands.
	input  wire logic want_a,
	input  wire logic want_b,
	input  wire logic echo_broken,
	// Device side.
	input  wire logic test_drive,
	output logic      torque_off_input_a,
	output logic      torque_off_input_b,
	output logic      test_echo
);
	// Both inputs move on the same edge, so a single high input only appears when asked for.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			torque_off_input_a <= 1'b0;
			torque_off_input_b <= 1'b0;
		end else begin
			torque_off_input_a <= want_a;
			torque_off_input_b <= want_b;
		end
	end
	// A healthy path echoes the drive one cycle late; a broken one sticks low.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			test_echo <= 1'b0;
		else
			test_echo <= test_drive & ~echo_broken;
	end
endmodule : torque_off_partner

/* File: sim/torque_off_supervisor_tb_top.sv */
// Self-checking bench of the torque-off and protection supervisor.
`timescale 1ns/1ps
module torque_off_supervisor_tb_top;
	localparam int MS = 4;
	localparam logic [7:0] RA [5] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
	localparam logic [15:0] RST [5] = '{16'h0258, 16'h0032, 16'h01f4, 16'h0258, 16'h01f4};
	localparam logic [15:0] LO [5] = '{16'h0032, 16'h0000, 16'h0064, 16'h0064, 16'h0001};
	localparam logic [15:0] HI [5] = '{16'h0258, 16'h01f4, 16'h0258, 16'h0258, 16'hfde8};
	logic        pclk, presetn, psel, penable, pwrite, sample_valid, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rng;
	logic [15:0] supply_volts, motor_current;
	logic        test_echo, test_drive, power_stage_enable, current_limit_active, tcp_mode, can_mode;
	logic        status_led, status_led_fault, irq, torque_off_input_a, torque_off_input_b;
	logic        want_a, want_b, echo_broken;
	logic [33:0] notes [$];
	logic [33:0] nt;
	int          err_count, total_checks, cycles, n, m;

	torque_off_supervisor #(.MS_CYCLES(MS), .MEAS_W(16)) torque_off_supervisor_i (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .torque_off_input_a, .torque_off_input_b,
		.test_echo, .test_drive, .sample_valid, .supply_volts, .motor_current, .power_stage_enable,
		.current_limit_active, .tcp_mode, .can_mode, .status_led, .status_led_fault, .irq);
	torque_off_partner torque_off_partner_i (.pclk, .presetn, .want_a, .want_b, .echo_broken, .test_drive,
		.torque_off_input_a, .torque_off_input_b, .test_echo);

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	function automatic logic [15:0] good();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return 16'(32'h0064 + rng % 32'h0190);
	endfunction : good

	task automatic c32(input string what, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : c32

	task automatic c1(input string what, input logic e, input logic g);
		c32(what, 32'(e), 32'(g));
	endtask : c1

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report

	// The expectation is queued before the request, so the monitor never pops an empty queue.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic er);
		notes.push_back({wr, er, d});
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic at(input int k);
		repeat (k) @(posedge pclk);
		@(negedge pclk);
	endtask : at

	task automatic smp(input logic [15:0] v, input logic [15:0] i);
		@(posedge pclk);
		sample_valid <= 1'b1;
		supply_volts <= v;
		motor_current <= i;
		@(posedge pclk);
		sample_valid <= 1'b0;
		at(3);
	endtask : smp

	always @(posedge pclk) begin
		if (pready === 1'b1) begin
			nt = notes.pop_front();
			c1("pslverr", nt[32], pslverr);
			if (!nt[33])
				c32("prdata", nt[31:0], prdata);
		end
	end

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 60000) begin
			err_count++;
			final_report();
		end
	end

	initial begin
		{presetn, psel, penable, pwrite, sample_valid, want_a, want_b, echo_broken} = 8'h00;
		{paddr, pwdata, supply_volts, motor_current} = 72'h0;
		rng = 32'h00014764;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		at(2);
		c1("tcp_mode", 1'b1, tcp_mode);
		c1("can_mode", 1'b0, can_mode);
		apb(0, 8'h00, 32'h2, 0);
		for (int k = 0; k < 5; k++)
			apb(0, RA[k], 32'(RST[k]), 0);
		apb(0, 8'h18, 32'h0, 0);
		apb(0, 8'h1c, 32'h0, 0);
		// Counting starts at a rising edge of the indicator, never in the middle of a flash.
		while (status_led === 1'b1) @(negedge pclk);
		while (status_led !== 1'b1) @(negedge pclk);
		for (n = 0; status_led === 1'b1; n++) @(negedge pclk);
		for (m = n; status_led !== 1'b1; m++) @(negedge pclk);
		c32("led on", 32'(100 * MS), 32'(n));
		c32("led period", 32'(2000 * MS), 32'(m));
		c1("led_fault", 1'b0, status_led_fault);
		apb(1, 8'h00, 32'h6, 0);
		at(1);
		c1("tcp_mode", 1'b1, tcp_mode);
		c1("can_mode", 1'b0, can_mode);
		apb(1, 8'h00, 32'h4, 0);
		at(1);
		c1("tcp_mode", 1'b0, tcp_mode);
		c1("can_mode", 1'b1, can_mode);
		apb(1, 8'h00, 32'h2, 0);
		apb(1, 8'h40, 32'hffffffff, 1);
		for (int k = 0; k < 5; k++) begin
			apb(1, RA[k], 32'h0, 0);
			apb(0, RA[k], 32'(LO[k]), 0);
			apb(1, RA[k], 32'hffff, 0);
			apb(0, RA[k], 32'(HI[k]), 0);
			apb(1, RA[k], 32'(RST[k]), 0);
		end
		apb(1, 8'h1c, 32'h7f, 0);
		smp(good(), 16'h0);
		c1("stage", 1'b1, power_stage_enable);
		smp(16'h0259, 16'h0);
		c1("stage", 1'b0, power_stage_enable);
		c1("irq", 1'b1, irq);
		c1("led_fault", 1'b1, status_led_fault);
		smp(16'h0258, 16'h0);
		c1("stage", 1'b1, power_stage_enable);
		smp(16'h0031, 16'h0);
		c1("stage", 1'b0, power_stage_enable);
		smp(16'h0032, 16'h0);
		c1("stage", 1'b1, power_stage_enable);
		apb(0, 8'h18, 32'hc, 0);
		at(2);
		c1("irq", 1'b0, irq);
		smp(good(), 16'h02d1);
		c1("stage", 1'b0, power_stage_enable);
		c1("limit", 1'b1, current_limit_active);
		smp(good(), 16'h0);
		c1("stage", 1'b0, power_stage_enable);
		apb(1, 8'h00, 32'ha, 0);
		at(2);
		c1("stage", 1'b1, power_stage_enable);
		apb(0, 8'h18, 32'h60, 0);
		apb(1, 8'h10, 32'h64, 0);
		apb(1, 8'h14, 32'h5, 0);
		smp(good(), 16'h00c8);
		c1("stage", 1'b1, power_stage_enable);
		at(40);
		c1("stage", 1'b0, power_stage_enable);
		smp(good(), 16'h0);
		c1("stage", 1'b0, power_stage_enable);
		apb(1, 8'h00, 32'ha, 0);
		at(2);
		c1("stage", 1'b1, power_stage_enable);
		apb(0, 8'h18, 32'h10, 0);
		apb(1, 8'h10, 32'h258, 0);
		apb(1, 8'h14, 32'h1f4, 0);
		smp(good(), 16'h01f5);
		c1("limit", 1'b1, current_limit_active);
		smp(good(), 16'h01f4);
		c1("limit", 1'b0, current_limit_active);
		apb(0, 8'h18, 32'h40, 0);
		apb(1, 8'h1c, 32'h0, 0);
		smp(16'h0259, 16'h0);
		c1("irq", 1'b0, irq);
		smp(good(), 16'h0);
		apb(0, 8'h18, 32'h4, 0);
		apb(1, 8'h00, 32'h3, 0);
		at(2);
		c1("stage", 1'b0, power_stage_enable);
		@(posedge pclk);
		want_a <= 1'b1;
		want_b <= 1'b1;
		at(4);
		c1("test_drive", 1'b1, test_drive);
		for (n = 0; power_stage_enable !== 1'b1 && n < 2000; n++) @(negedge pclk);
		c1("stage", 1'b1, power_stage_enable);
		c1("test length", 1'b1, n >= 790);
		@(posedge pclk);
		want_b <= 1'b0;
		at(4);
		c1("stage", 1'b0, power_stage_enable);
		@(posedge pclk);
		echo_broken <= 1'b1;
		want_b <= 1'b1;
		at(3);
		c1("stage", 1'b0, power_stage_enable);
		at(1000);
		c1("stage", 1'b0, power_stage_enable);
		apb(0, 8'h18, 32'h3, 0);
		final_report();
	end
endmodule : torque_off_supervisor_tb_top
